// ---- mlfh_defs.svh ----
// Constants for the motor lock fault handler: register map, fields, timing.
// Assumes a 40 MHz system clock and APB with 32-bit data.
`ifndef MLFH_DEFS_SVH
`define MLFH_DEFS_SVH

// ************************************************
// Register byte addresses
// ************************************************
`define MLFH_A_CTRL 12'h000
`define MLFH_A_OVSPD 12'h004
`define MLFH_A_SYNC 12'h008
`define MLFH_A_OPEN 12'h00C
`define MLFH_A_STAT 12'h010
`define MLFH_A_IRQ_EN 12'h014
`define MLFH_A_IRQ_CLR 12'h018
`define MLFH_A_IRQ_ST 12'h01C

// ************************************************
// Control fields
// ************************************************
`define MLFH_CTRL_MODE_LSB 0
`define MLFH_CTRL_OVS_EN 4
`define MLFH_CTRL_SYN_EN 5
`define MLFH_CTRL_OPN_EN 6
`define MLFH_CTRL_START_LSB 8
`define MLFH_CTRL_RETRY_LSB 12
`define MLFH_CTRL_CLR 16
`define MLFH_CTRL_RESET 32'h0000_0000

// ************************************************
// Mode codes and startup code
// ************************************************
`define MLFH_MODE_REPORT 4'h8
`define MLFH_START_PROBE 2'h2

// ************************************************
// Timing
// ************************************************
`define MLFH_CLK_HZ 40000000
`define MLFH_RETRY_BASE_MS 100
`define MLFH_RETRY_BASE_CYC (`MLFH_CLK_HZ / 1000 * `MLFH_RETRY_BASE_MS)
`define MLFH_PROBE_DIV0 4
`define MLFH_PROBE_DIV1 40
`define MLFH_PROBE_DIV2 400
`define MLFH_PROBE_DIV3 4000

`endif

// ---- mlfh_pkg.sv ----
// Types for the motor lock fault handler.
// Assumes mlfh_defs.svh supplies the numbers.
package mlfh_pkg;

  typedef enum logic [3:0] {
    MLFH_RUN = 4'b0001,
    MLFH_LATCH = 4'b0010,
    MLFH_RETRY = 4'b0100,
    MLFH_REPORT = 4'b1000
  } mlfh_state_e;

  typedef enum logic [3:0] {
    MLFH_P_IDLE = 4'b0001,
    MLFH_P_RISE = 4'b0010,
    MLFH_P_DECAY = 4'b0100,
    MLFH_P_DONE = 4'b1000
  } mlfh_probe_e;

  typedef struct packed {
    logic [2:0] high_on;
    logic [2:0] low_on;
  } mlfh_gate_s;

  typedef struct packed {
    logic probe_rate_fault;
    logic probe_decay_timeout_fault;
    logic probe_rise_timeout_fault;
    logic open_motor_lock;
    logic sync_loss_lock;
    logic overspeed_lock;
    logic motor_lock;
    logic controller_fault;
  } mlfh_flags_s;

endpackage : mlfh_pkg

// ---- mlfh_lock_handler.sv ----
// Motor lock fault handler: lock detectors, response modes, probe timers, APB registers.
// Assumes synchronous inputs on clk_sys and an APB master that waits for pready.
//
// Notes on behaviour
// RULE1: Mode 00xx: lock event applies low-bit gate state and drives fault pin low.
// RULE2: Gate state codes: all off, recirculate, all high on, all low on.
// RULE3: Latched mode sets controller, motor lock and specific condition flags.
// RULE4: Latched shutdown ends only after condition clears and clear command.
// RULE5: Mode 01xx applies same gate states, fault pin low, sets flags.
// RULE6: Retry mode recovers after retry interval, clearing flags without software.
// RULE7: Mode 1000 only reports flags; gate drive continues.
// RULE8: Report flags stay until condition gone and clear command written.
// RULE9: Mode 1xx1 takes no action on lock events.
// RULE10: Speed above overspeed threshold raises overspeed lock.
// RULE11: Missed zero-crossing count reaching limit raises sync loss lock.
// RULE12: Low-side current below threshold beyond filter time raises open motor lock.
// RULE13: Each detector has its own enable; disabled never raises events.
// RULE14: Probe startup times rise and decay with 12-bit timers; overflow fails.
// RULE15: Rise timed at 10 MHz, 1 MHz, 100 kHz, 10 kHz; all overflow faults.
// RULE16: Decay timed with same four rates; all overflow raises decay fault.
// RULE17: Probe pulse commanded before decay completes raises probe rate fault.
// RULE18: Latched faults hold partial shutdown until clear written after condition clears.
// RULE19: Modes 1010, 1100, 1110 act as disabled.
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "mlfh_defs.svh"

module mlfh_lock_handler #(
  parameter int SPEED_W = 16,
  parameter int CUR_W = 12,
  parameter int MISS_W = 4,
  parameter int FILT_W = 16,
  parameter int RETRY_BASE = `MLFH_RETRY_BASE_CYC
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [SPEED_W-1:0] speed_meas,
  input wire logic zc_window_end,
  input wire logic zc_detected,
  input wire logic [CUR_W-1:0] low_side_current,
  input wire logic [5:0] gate_cmd,
  input wire logic [5:0] gate_switching,
  input wire logic recirc_done,
  input wire logic probe_start,
  input wire logic probe_at_threshold,
  input wire logic probe_at_zero,
  output logic [5:0] gate_out,
  output logic fault_out_n,
  output logic irq
);

  // ************************************************
  // Registers
  // ************************************************
  logic [31:0] ctrl_r;
  logic [SPEED_W-1:0] overspeed_threshold_r;
  logic [MISS_W-1:0] sync_miss_limit_r;
  logic [CUR_W-1:0] open_motor_current_threshold_r;
  logic [FILT_W-1:0] open_motor_filter_time_r;
  logic [7:0] irq_en_r;
  logic [7:0] irq_st_r;
  mlfh_pkg::mlfh_flags_s flags_r;
  mlfh_pkg::mlfh_state_e state_r;
  mlfh_pkg::mlfh_state_e state_nxt;
  logic [5:0] gate_hold_r;
  logic [MISS_W-1:0] miss_cnt_r;
  logic [FILT_W-1:0] filt_cnt_r;
  logic [31:0] retry_cnt_r;

  // ************************************************
  // APB decode
  // ************************************************
  wire logic wr_stb = psel && penable && pwrite;
  wire logic rd_phase = psel && !penable;
  wire logic hit_ctrl = paddr == `MLFH_A_CTRL;
  wire logic hit_ovs = paddr == `MLFH_A_OVSPD;
  wire logic hit_sync = paddr == `MLFH_A_SYNC;
  wire logic hit_open = paddr == `MLFH_A_OPEN;
  wire logic hit_stat = paddr == `MLFH_A_STAT;
  wire logic hit_ien = paddr == `MLFH_A_IRQ_EN;
  wire logic hit_iclr = paddr == `MLFH_A_IRQ_CLR;
  wire logic hit_ist = paddr == `MLFH_A_IRQ_ST;
  wire logic hit_any = hit_ctrl | hit_ovs | hit_sync | hit_open | hit_stat | hit_ien | hit_iclr | hit_ist;
  wire logic [31:0] rd_mux =
    hit_ctrl ? ctrl_r :
    hit_ovs ? 32'(overspeed_threshold_r) :
    hit_sync ? 32'(sync_miss_limit_r) :
    hit_open ? {open_motor_filter_time_r, 16'(open_motor_current_threshold_r)} :
    hit_stat ? {state_r, 20'h0_0000, flags_r} :
    hit_ien ? {24'h00_0000, irq_en_r} :
    hit_ist ? {24'h00_0000, irq_st_r} : 32'h0000_0000;
  // Clear command is a self-clearing strobe, so it reads back as zero
  wire logic clr_cmd = wr_stb && hit_ctrl && pwdata[`MLFH_CTRL_CLR];

  // ************************************************
  // Fields
  // ************************************************
  wire logic [3:0] mode = ctrl_r[`MLFH_CTRL_MODE_LSB +: 4];
  wire logic [1:0] startup_method = ctrl_r[`MLFH_CTRL_START_LSB +: 2];
  wire logic [3:0] lock_retry_time_sel = ctrl_r[`MLFH_CTRL_RETRY_LSB +: 4];
  wire logic overspeed_check_enable = ctrl_r[`MLFH_CTRL_OVS_EN];
  wire logic sync_loss_check_enable = ctrl_r[`MLFH_CTRL_SYN_EN];
  wire logic open_motor_check_enable = ctrl_r[`MLFH_CTRL_OPN_EN];

  // ************************************************
  // Lock detectors
  // ************************************************
  wire logic ovs_cond = overspeed_check_enable && (speed_meas > overspeed_threshold_r); // RULE10 RULE13
  wire logic miss_evt = zc_window_end && !zc_detected;
  wire logic [MISS_W-1:0] miss_inc = miss_cnt_r + MISS_W'(1);
  wire logic syn_cond = sync_loss_check_enable && (miss_cnt_r >= sync_miss_limit_r)
    && (sync_miss_limit_r != '0); // RULE11 RULE13
  wire logic cur_low = low_side_current < open_motor_current_threshold_r;
  wire logic opn_cond = open_motor_check_enable && cur_low
    && (filt_cnt_r > open_motor_filter_time_r); // RULE12 RULE13
  wire logic lock_any = ovs_cond | syn_cond | opn_cond;

  // ************************************************
  // Mode decode
  // ************************************************
  wire logic mode_latch = mode[3:2] == 2'b00; // RULE1
  wire logic mode_retry = mode[3:2] == 2'b01; // RULE5
  wire logic mode_report = mode == `MLFH_MODE_REPORT; // RULE7
  // Everything else, 1xx1 and the spare codes, is disabled
  wire logic mode_act = mode_latch | mode_retry | mode_report; // RULE9 RULE19
  wire logic lock_evt = lock_any && mode_act;

  // Retry interval is the 100 ms base times select plus one
  wire logic [31:0] retry_len = 32'(RETRY_BASE) * (32'h0000_0001 + 32'(lock_retry_time_sel));
  wire logic retry_done = retry_cnt_r >= retry_len;

  // ************************************************
  // Gate state for the active shutdown code
  // ************************************************
  // Recirculation keeps the conducting device on until energy is gone
  // Held command from the last running cycle, since the controller may move on
  wire logic [5:0] recirc_gate = recirc_done ? 6'h00 : (gate_hold_r & ~gate_switching);
  wire logic [5:0] shut_gate =
    (mode[1:0] == 2'b00) ? 6'h00 :
    (mode[1:0] == 2'b01) ? recirc_gate :
    (mode[1:0] == 2'b10) ? 6'h38 : 6'h07; // RULE2
  wire logic shut = (state_r == mlfh_pkg::MLFH_LATCH) || (state_r == mlfh_pkg::MLFH_RETRY);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      mlfh_pkg::MLFH_RUN:
      begin
        if (lock_evt && mode_latch)
          state_nxt = mlfh_pkg::MLFH_LATCH;
        else if (lock_evt && mode_retry)
          state_nxt = mlfh_pkg::MLFH_RETRY;
        else if (lock_evt && mode_report)
          state_nxt = mlfh_pkg::MLFH_REPORT;
      end
      mlfh_pkg::MLFH_LATCH:
        if (clr_cmd && !lock_any)
          state_nxt = mlfh_pkg::MLFH_RUN; // RULE4 RULE18
      mlfh_pkg::MLFH_RETRY:
        if (retry_done)
          state_nxt = mlfh_pkg::MLFH_RUN; // RULE6
      mlfh_pkg::MLFH_REPORT:
        if (clr_cmd && !lock_any)
          state_nxt = mlfh_pkg::MLFH_RUN; // RULE8
      default:
        state_nxt = mlfh_pkg::MLFH_RUN;
    endcase
  end

  // ************************************************
  // Initial position probe timing
  // ************************************************
  mlfh_pkg::mlfh_probe_e probe_r;
  logic [1:0] rate_r;
  logic [11:0] ptim_r;
  logic [12:0] pdiv_r;
  wire logic [12:0] div_len =
    (rate_r == 2'd0) ? 13'(`MLFH_PROBE_DIV0) :
    (rate_r == 2'd1) ? 13'(`MLFH_PROBE_DIV1) :
    (rate_r == 2'd2) ? 13'(`MLFH_PROBE_DIV2) : 13'(`MLFH_PROBE_DIV3); // RULE15 RULE16
  wire logic probe_on = startup_method == `MLFH_START_PROBE; // RULE14
  wire logic ptick = pdiv_r == div_len - 13'd1;
  wire logic povf = ptick && (ptim_r == 12'hFFF); // RULE14
  wire logic in_rise = probe_r == mlfh_pkg::MLFH_P_RISE;
  wire logic in_decay = probe_r == mlfh_pkg::MLFH_P_DECAY;
  wire logic rise_fail = in_rise && povf && (rate_r == 2'd3); // RULE15
  wire logic decay_fail = in_decay && povf && (rate_r == 2'd3); // RULE16
  wire logic rate_err = probe_start && in_decay; // RULE17
  wire logic restart = (in_rise && probe_at_threshold) || (in_decay && probe_at_zero) || povf;

  always_ff @(posedge clk_sys)
  begin
    if (reset || !probe_on)
    begin
      probe_r <= mlfh_pkg::MLFH_P_IDLE;
      rate_r <= 2'd0;
      ptim_r <= 12'h000;
      pdiv_r <= 13'h0000;
    end
    else
    begin
      pdiv_r <= (ptick || restart) ? 13'h0000 : pdiv_r + 13'd1;
      ptim_r <= restart ? 12'h000 : (ptick ? ptim_r + 12'd1 : ptim_r);
      case (probe_r)
        mlfh_pkg::MLFH_P_IDLE:
          if (probe_start)
            probe_r <= mlfh_pkg::MLFH_P_RISE;
        mlfh_pkg::MLFH_P_RISE:
          if (probe_at_threshold)
          begin
            probe_r <= mlfh_pkg::MLFH_P_DECAY;
            rate_r <= 2'd0;
          end
          else if (povf)
          begin
            rate_r <= rate_r + 2'd1;
            if (rate_r == 2'd3)
              probe_r <= mlfh_pkg::MLFH_P_DONE;
          end
        mlfh_pkg::MLFH_P_DECAY:
          if (probe_at_zero)
          begin
            probe_r <= mlfh_pkg::MLFH_P_IDLE;
            rate_r <= 2'd0;
          end
          else if (povf)
          begin
            rate_r <= rate_r + 2'd1;
            if (rate_r == 2'd3)
              probe_r <= mlfh_pkg::MLFH_P_DONE;
          end
        mlfh_pkg::MLFH_P_DONE:
          if (clr_cmd)
            probe_r <= mlfh_pkg::MLFH_P_IDLE;
        default:
          probe_r <= mlfh_pkg::MLFH_P_IDLE;
      endcase
    end
  end

  // ************************************************
  // Flags: set wins over clear
  // ************************************************
  wire logic flag_clr = (clr_cmd && !lock_any && !shut) || (clr_cmd && state_nxt == mlfh_pkg::MLFH_RUN)
    || (state_r == mlfh_pkg::MLFH_RETRY && retry_done); // RULE6 RULE8
  wire logic probe_clr = clr_cmd;
  wire logic [7:0] flag_set = {rate_err, decay_fail, rise_fail,
    opn_cond && lock_evt, syn_cond && lock_evt, ovs_cond && lock_evt,
    lock_evt, lock_evt | rise_fail | decay_fail | rate_err}; // RULE3 RULE5 RULE7
  wire logic [7:0] flag_keep = {{3{!probe_clr}}, {5{!flag_clr}}};
  wire logic [7:0] flags_nxt = (flags_r & flag_keep) | flag_set;

  // ************************************************
  // Sequential state
  // ************************************************
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ctrl_r <= `MLFH_CTRL_RESET;
      overspeed_threshold_r <= '1;
      sync_miss_limit_r <= '1;
      open_motor_current_threshold_r <= '0;
      open_motor_filter_time_r <= '1;
      irq_en_r <= 8'h00;
    end
    else if (wr_stb)
    begin
      if (hit_ctrl)
        ctrl_r <= pwdata & ~(32'h0000_0001 << `MLFH_CTRL_CLR);
      if (hit_ovs)
        overspeed_threshold_r <= pwdata[SPEED_W-1:0];
      if (hit_sync)
        sync_miss_limit_r <= pwdata[MISS_W-1:0];
      if (hit_open)
        {open_motor_filter_time_r, open_motor_current_threshold_r} <= {pwdata[31:16], pwdata[CUR_W-1:0]};
      if (hit_ien)
        irq_en_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_r <= mlfh_pkg::MLFH_RUN;
      flags_r <= '0;
      irq_st_r <= 8'h00;
      miss_cnt_r <= '0;
      filt_cnt_r <= '0;
      retry_cnt_r <= 32'h0000_0000;
      gate_hold_r <= 6'h00;
      gate_out <= 6'h00;
      fault_out_n <= 1'b1;
      irq <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      flags_r <= flags_nxt;
      irq_st_r <= (irq_st_r & ~((wr_stb && hit_iclr) ? pwdata[7:0] : 8'h00)) | (flags_nxt & ~flags_r);
      irq <= |((irq_st_r | (flags_nxt & ~flags_r)) & irq_en_r);
      miss_cnt_r <= zc_detected ? '0 : (miss_evt && miss_inc != '0 ? miss_inc : miss_cnt_r); // RULE11
      filt_cnt_r <= (!cur_low) ? '0 : ((&filt_cnt_r) ? filt_cnt_r : filt_cnt_r + FILT_W'(1)); // RULE12
      retry_cnt_r <= (state_r == mlfh_pkg::MLFH_RETRY) ? retry_cnt_r + 32'h0000_0001 : 32'h0000_0000;
      if (state_r == mlfh_pkg::MLFH_RUN)
        gate_hold_r <= gate_cmd;
      gate_out <= (state_nxt == mlfh_pkg::MLFH_LATCH || state_nxt == mlfh_pkg::MLFH_RETRY) ? shut_gate
        : gate_cmd; // RULE1 RULE5 RULE7
      fault_out_n <= !(state_nxt == mlfh_pkg::MLFH_LATCH || state_nxt == mlfh_pkg::MLFH_RETRY
        || flags_nxt[7:5] != 3'b000); // RULE1 RULE5 RULE18
      pready <= rd_phase;
      pslverr <= rd_phase && !hit_any;
      prdata <= (rd_phase && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

endmodule : mlfh_lock_handler
`default_nettype wire

// ---- mlfh_bridge_model.sv ----
// Far-side model: half-bridges, coil current, probe current.
// Assumes gate_out from the handler and motor_open from the bench.
`timescale 1ns/1ps
`default_nettype none
module mlfh_bridge_model (
  input wire logic clk_sys,
  input wire logic [5:0] gate_out,
  input wire logic motor_open,
  input wire logic probe_start,
  output logic [11:0] low_side_current,
  output logic recirc_done,
  output logic probe_at_threshold,
  output logic probe_at_zero
);
  logic [4:0] phase_r = 5'h00;
  logic [3:0] recirc_r = 4'h0;
  // Open winding carries no current at all
  assign low_side_current = motor_open ? 12'h000 : 12'h0FF;
  assign probe_at_threshold = phase_r == 5'h0F;
  assign probe_at_zero = phase_r == 5'h00;
  assign recirc_done = recirc_r == 4'hF;
  // Probe current rises 15 cycles, decays 17; decay must take time to catch early pulses
  always @(posedge clk_sys)
  begin
    phase_r <= probe_start ? 5'h01 : (probe_at_zero ? 5'h00 : phase_r + 5'h01);
    recirc_r <= (gate_out == 6'h00) ? 4'h0 : (recirc_done ? recirc_r : recirc_r + 4'h1);
  end
endmodule : mlfh_bridge_model
`default_nettype wire

// ---- mlfh_lock_handler_assertions.sv ----
// Checker for the lock handler pins and bus.
// Assumes bind to mlfh_lock_handler; shadows CTRL and threshold writes.
`timescale 1ns/1ps
`default_nettype none
`include "mlfh_defs.svh"
module mlfh_lock_checker #(
  parameter int SPEED_W = 16,
  parameter int RETRY_BASE = 20
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [SPEED_W-1:0] speed_meas,
  input wire logic [5:0] gate_cmd,
  input wire logic [5:0] gate_switching,
  input wire logic [5:0] gate_out,
  input wire logic fault_out_n
);
  // ********
  // Shadow state
  // ********
  logic [31:0] ctrl_r;
  logic [31:0] thr_r;
  logic [15:0] low_r;
  int retry_len;
  wire wr_go = psel & penable & pwrite & pready;
  wire [3:0] mode = ctrl_r[3:0];
  wire no_probe = ctrl_r[9:8] != 2'h2;
  wire clr_wr = wr_go & (paddr == `MLFH_A_CTRL) & pwdata[`MLFH_CTRL_CLR];
  assign retry_len = RETRY_BASE * (int'(ctrl_r[15:12]) + 1);
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ctrl_r <= `MLFH_CTRL_RESET;
      thr_r <= 32'h0;
      low_r <= 16'h0;
    end
    else
    begin
      if (wr_go && paddr == `MLFH_A_CTRL) ctrl_r <= pwdata;
      if (wr_go && paddr == `MLFH_A_OVSPD) thr_r <= pwdata;
      low_r <= fault_out_n ? 16'h0 : low_r + 16'h1;
    end
  end
  // ********
  // Properties
  // ********
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  property p_ovs;
    mode[3:2] == 2'h0 && ctrl_r[4] && speed_meas > thr_r[SPEED_W-1:0] |=> !fault_out_n;
  endproperty
  a_ovs: assert property (p_ovs) else $error("overspeed not latched");
  property p_gate;
    !mode[3] && mode[1:0] != 2'h1 && no_probe && !fault_out_n |-> gate_out == {{3{mode[1:0] == 2'h2}}, {3{mode[1:0] == 2'h3}}};
  endproperty
  a_gate: assert property (p_gate) else $error("wrong lock gate state");
  property p_recirc;
    !mode[3] && mode[1:0] == 2'h1 && !fault_out_n |-> (gate_out & gate_switching) == 6'h00;
  endproperty
  a_recirc: assert property (p_recirc) else $error("switching gate left on");
  property p_clear;
    $rose(fault_out_n) && mode[3:2] == 2'h0 && no_probe |-> $past(clr_wr);
  endproperty
  a_clear: assert property (p_clear) else $error("latched fault left without clear");
  property p_retry;
    $rose(fault_out_n) && mode[3:2] == 2'h1 |-> low_r + 2 >= retry_len && low_r <= retry_len + 2;
  endproperty
  a_retry: assert property (p_retry) else $error("retry interval wrong");
  property p_quiet;
    mode[3] && no_probe |-> fault_out_n;
  endproperty
  a_quiet: assert property (p_quiet) else $error("fault pin low in passive mode");
  property p_follow;
    mode[3] && no_probe |=> gate_out == $past(gate_cmd);
  endproperty
  a_follow: assert property (p_follow) else $error("gates not following command");
  property p_noen;
    !(|ctrl_r[6:4]) && no_probe && fault_out_n |=> fault_out_n;
  endproperty
  a_noen: assert property (p_noen) else $error("disabled detector faulted");
  property p_ready;
    psel && !penable |=> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_refuse;
    pready && !pwrite && paddr > `MLFH_A_IRQ_ST |-> pslverr && prdata == 32'h0;
  endproperty
  a_refuse: assert property (p_refuse) else $error("unmapped read not refused");
  c_latch: cover property (mode[3:2] == 2'h0 ##1 $fell(fault_out_n));
  c_retry: cover property ($rose(fault_out_n) && mode[3:2] == 2'h1);
  c_refuse: cover property (pready && pslverr);
endmodule : mlfh_lock_checker
bind mlfh_lock_handler mlfh_lock_checker #(.SPEED_W(SPEED_W), .RETRY_BASE(RETRY_BASE)) mlfh_lock_checker_inst (
  .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .speed_meas(speed_meas), .gate_cmd(gate_cmd), .gate_switching(gate_switching),
  .gate_out(gate_out), .fault_out_n(fault_out_n));
`default_nettype wire

// ---- test_motor_lock_fault_handler.sv ----
// Self-checking bench for the lock handler with a bridge model.
// Assumes handler, checker and bridge model compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "mlfh_defs.svh"
module test_motor_lock_fault_handler;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, recirc_done, probe_at_threshold, probe_at_zero, fault_out_n, irq, f_s, i_s;
  logic [15:0] speed_meas = 16'h0;
  logic zc_window_end = 1'b0, zc_detected = 1'b0, probe_start = 1'b0, motor_open = 1'b0;
  logic [11:0] low_side_current;
  logic [5:0] gate_cmd = 6'h00, gate_switching = 6'h09, gate_out, g_s;
  logic [3:0] dis_modes [7] = '{4'h9, 4'hB, 4'hD, 4'hF, 4'hA, 4'hC, 4'hE};
  int error_cnt = 0, cmp_count = 0, cyc = 0, seed;
  always #12.5 clk_sys = ~clk_sys;
  // Snapshot at negedge keeps checks clear of edge races
  always @(negedge clk_sys) {g_s, f_s, i_s} <= {gate_out, fault_out_n, irq};
  mlfh_lock_handler #(.RETRY_BASE(20)) mlfh_lock_handler_inst (.clk_sys(clk_sys), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .speed_meas(speed_meas), .zc_window_end(zc_window_end),
    .zc_detected(zc_detected), .low_side_current(low_side_current), .gate_cmd(gate_cmd),
    .gate_switching(gate_switching), .recirc_done(recirc_done), .probe_start(probe_start),
    .probe_at_threshold(probe_at_threshold), .probe_at_zero(probe_at_zero), .gate_out(gate_out),
    .fault_out_n(fault_out_n), .irq(irq));
  mlfh_bridge_model mlfh_bridge_model_inst (.clk_sys(clk_sys), .gate_out(gate_out),
    .motor_open(motor_open), .probe_start(probe_start), .low_side_current(low_side_current),
    .recirc_done(recirc_done), .probe_at_threshold(probe_at_threshold), .probe_at_zero(probe_at_zero));
  // ********
  // Tasks and expectations
  // ********
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic chkf(input logic e);
    chk(32'(f_s), 32'(e));
  endtask : chkf
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    logic err;
    apb(1'b0, a, 32'h0, q, err);
    chk(q & m, e);
  endtask : rd
  task automatic pulse_probe;
    probe_start <= 1'b1;
    tick(1);
    probe_start <= 1'b0;
  endtask : pulse_probe
  function automatic logic [5:0] gate_mask(input int m);
    return (m % 4 == 1) ? gate_switching : 6'h3F;
  endfunction : gate_mask
  function automatic logic [5:0] gate_exp(input int m);
    return {{3{m % 4 == 2}}, {3{m % 4 == 3}}};
  endfunction : gate_exp
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // Ceiling well above the few hundred cycles needed
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end
  // ********
  // Scenarios
  // ********
  initial
  begin
    logic [31:0] q;
    logic e;
    seed = 90186;
    tick(2);
    reset <= 1'b0;
    rd(`MLFH_A_CTRL, 32'hFFFF_FFFF, `MLFH_CTRL_RESET);
    apb(1'b0, 12'h040, 32'h0, q, e);
    chk(q, 32'h0);
    chk(32'(e), 32'h1);
    wr(`MLFH_A_OVSPD, 32'h4000);
    wr(`MLFH_A_SYNC, 32'h2);
    wr(`MLFH_A_OPEN, 32'h0005_0040);
    for (int m = 0; m < 4; m++)
    begin
      gate_cmd <= 6'($random(seed));
      speed_meas <= 16'h4000;
      wr(`MLFH_A_CTRL, 32'h10 | m);
      tick(3);
      chkf(1'b1);
      speed_meas <= 16'h4001;
      tick(3);
      chkf(1'b0);
      chk(32'(g_s & gate_mask(m)), 32'(gate_exp(m)));
      rd(`MLFH_A_STAT, 32'hFF, 32'h07);
      wr(`MLFH_A_CTRL, 32'h1_0010 | m);
      tick(2);
      chkf(1'b0);
      speed_meas <= 16'($random(seed)) & 16'h3FFF;
      wr(`MLFH_A_CTRL, 32'h1_0010 | m);
      tick(2);
      chkf(1'b1);
      chk(32'(g_s), 32'(gate_cmd));
      rd(`MLFH_A_STAT, 32'hFF, 32'h00);
    end
    $display("done latched");
    for (int m = 4; m < 8; m++)
    begin
      wr(`MLFH_A_CTRL, 32'h20 | m);
      repeat (2)
      begin
        zc_window_end <= 1'b1;
        tick(1);
        zc_window_end <= 1'b0;
        tick(1);
      end
      tick(2);
      chkf(1'b0);
      chk(32'(g_s & gate_mask(m)), 32'(gate_exp(m)));
      rd(`MLFH_A_STAT, 32'hFF, 32'h0B);
      zc_detected <= 1'b1;
      tick(1);
      zc_detected <= 1'b0;
      tick(30);
      chkf(1'b1);
      rd(`MLFH_A_STAT, 32'hFF, 32'h00);
    end
    $display("done retry");
    gate_cmd <= 6'($random(seed));
    wr(`MLFH_A_CTRL, 32'h48);
    wr(`MLFH_A_IRQ_EN, 32'h10);
    motor_open <= 1'b1;
    tick(12);
    chkf(1'b1);
    chk(32'(g_s), 32'(gate_cmd));
    chk(32'(i_s), 32'h1);
    rd(`MLFH_A_STAT, 32'hFF, 32'h13);
    rd(`MLFH_A_IRQ_ST, 32'h10, 32'h10);
    wr(`MLFH_A_IRQ_EN, 32'h00);
    tick(2);
    chk(32'(i_s), 32'h0);
    wr(`MLFH_A_IRQ_EN, 32'h10);
    wr(`MLFH_A_IRQ_CLR, 32'h10);
    tick(2);
    chk(32'(i_s), 32'h0);
    rd(`MLFH_A_IRQ_CLR, 32'hFFFF_FFFF, 32'h0);
    motor_open <= 1'b0;
    rd(`MLFH_A_STAT, 32'hFF, 32'h13);
    wr(`MLFH_A_CTRL, 32'h1_0048);
    rd(`MLFH_A_STAT, 32'hFF, 32'h00);
    $display("done report");
    speed_meas <= 16'hFFFF;
    for (int i = 0; i < 7; i++)
    begin
      gate_cmd <= 6'($random(seed));
      wr(`MLFH_A_CTRL, 32'h70 | dis_modes[i]);
      tick(4);
      chkf(1'b1);
      chk(32'(g_s), 32'(gate_cmd));
      rd(`MLFH_A_STAT, 32'hFF, 32'h00);
    end
    wr(`MLFH_A_CTRL, 32'h0);
    tick(4);
    chkf(1'b1);
    rd(`MLFH_A_STAT, 32'hFF, 32'h00);
    $display("done disabled");
    speed_meas <= 16'h0;
    wr(`MLFH_A_CTRL, 32'h208);
    pulse_probe();
    tick(40);
    rd(`MLFH_A_STAT, 32'hE0, 32'h00);
    pulse_probe();
    tick(20);
    pulse_probe();
    tick(3);
    rd(`MLFH_A_STAT, 32'h80, 32'h80);
    chkf(1'b0);
    tick(30);
    wr(`MLFH_A_CTRL, 32'h1_0208);
    tick(2);
    chkf(1'b1);
    $display("done probe");
    tally_and_finish();
  end
endmodule : test_motor_lock_fault_handler
`default_nettype wire
